// >>> mct_irq_port.sv
// What this block does
// R1: five separate 8-bit interrupt enable registers
// R2: enable registers reset and standby to F8
// R3: bits 7..3 read one, ignore writes
// R4: bit 2 gates wrap interrupt request
// R5: bit 1 gates match B interrupt request
// R6: bit 0 gates match A interrupt request
// R7: enable bits read/write, zero after init
// R8: counter, general, buffer registers are 16-bit
// R9: 16-bit registers take word or byte access
// R10: other registers use 8-bit path
// R11: processor splits word to 8-bit registers
// R12: wrap flag set on counter wrap
// R13: flag cleared by read one, write zero
// R14: match flag set on compare or capture
// R15: request equals flag and enable; here the request is registered and follows flag and enable one edge late
// R16: upper byte even address, lower odd
//
// enable logic and processor register port of a five-channel timer
// assumes a single-cycle processor access: request in, data next edge
module mct_irq_port (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic STANDBY,
  // processor access
  input mct_pkg::mct_req_t CPU_REQ,
  input wire logic CPU_BYTE_ODD,
  output logic [15:0] CPU_RDATA,
  // counter-side events per channel
  input wire logic [4:0] CNT_TICK,
  input wire logic [4:0] CNT_DOWN,
  input wire logic [4:0] CAP_A,
  input wire logic [4:0] CAP_B,
  input wire logic [4:0] CMP_MODE_A,
  input wire logic [4:0] CMP_MODE_B,
  // interrupt requests
  output logic [4:0] WRAP_IRQ,
  output logic [4:0] MATCH_B_IRQ,
  output logic [4:0] MATCH_A_IRQ
);
  import mct_pkg::*;
  logic [2:0] timer_irq_enable_r [NUM_CH];
  logic [7:0] timer_control_reg_r [NUM_CH];
  logic [2:0] timer_flag_reg [NUM_CH];
  logic [15:0] timer_count [NUM_CH];
  logic [15:0] general_reg_a [NUM_CH];
  logic [15:0] general_reg_b [NUM_CH];
  logic [15:0] buffer_reg_a [NUM_CH];
  logic [15:0] buffer_reg_b [NUM_CH];
  logic [15:0] rdata_nxt;
  logic wr_hi;
  logic wr_lo;
  logic [15:0] wdata16;

  // word access carries both halves; byte lands on its half
  assign wr_hi = CPU_REQ.sel && CPU_REQ.wr && (CPU_REQ.word || !CPU_BYTE_ODD); // [R16]
  assign wr_lo = CPU_REQ.sel && CPU_REQ.wr && (CPU_REQ.word || CPU_BYTE_ODD); // [R16]
  assign wdata16 = CPU_REQ.word ? CPU_REQ.wdata : {CPU_REQ.wdata[7:0], CPU_REQ.wdata[7:0]};

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : ch
      logic hit;
      logic [15:0] cnt_nxt;
      logic wrap_evt;
      mct_evt_t evt;
      assign hit = CPU_REQ.sel && (CPU_REQ.ch == 3'(g));
      assign cnt_nxt = CNT_DOWN[g] ? timer_count[g] - CNT_ONE : timer_count[g] + CNT_ONE;
      assign wrap_evt = CNT_TICK[g] && (CNT_DOWN[g] ? (timer_count[g] == CNT_MIN)
                                                    : (timer_count[g] == CNT_MAX)); // [R12]
      assign evt.wrap = wrap_evt;
      assign evt.match_a = (CMP_MODE_A[g] && CNT_TICK[g] && timer_count[g] == general_reg_a[g])
                           || CAP_A[g]; // [R14]
      assign evt.match_b = (CMP_MODE_B[g] && CNT_TICK[g] && timer_count[g] == general_reg_b[g])
                           || CAP_B[g]; // [R14]

      // one enable register per channel, only three bits stored
      always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          timer_irq_enable_r[g] <= IRQ_EN_RESET[2:0]; // [R1] [R2] [R7]
        end else if (STANDBY) begin
          timer_irq_enable_r[g] <= IRQ_EN_RESET[2:0]; // [R2]
        end else if (hit && CPU_REQ.wr && CPU_REQ.idx == IDX_IRQ_EN) begin
          timer_irq_enable_r[g] <= CPU_REQ.wdata[2:0]; // [R3] [R7] [R10]
        end
      end

      // control register kept as a plain 8-bit store
      always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          timer_control_reg_r[g] <= RD_NONE;
        end else if (STANDBY) begin
          timer_control_reg_r[g] <= RD_NONE;
        end else if (hit && CPU_REQ.wr && CPU_REQ.idx == IDX_CTRL) begin
          timer_control_reg_r[g] <= CPU_REQ.wdata[7:0]; // [R10]
        end
      end

      mct_chan_flags u_flags (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .standby(STANDBY),
        .evt(evt),
        .flag_rd(hit && !CPU_REQ.wr && CPU_REQ.idx == IDX_FLAG),
        .flag_wr(hit && CPU_REQ.wr && CPU_REQ.idx == IDX_FLAG),
        .flag_wdata(CPU_REQ.wdata[2:0]),
        .flags(timer_flag_reg[g])
      );

      // 16-bit registers on the wide path
      mct_reg16 u_cnt (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .cpu_wr_hi(hit && wr_hi && CPU_REQ.idx == IDX_CNT), // [R8] [R9]
        .cpu_wr_lo(hit && wr_lo && CPU_REQ.idx == IDX_CNT),
        .cpu_wdata(wdata16),
        .hw_ld(CNT_TICK[g]),
        .hw_data(cnt_nxt),
        .q(timer_count[g])
      );
      mct_reg16 u_gra (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .cpu_wr_hi(hit && wr_hi && CPU_REQ.idx == IDX_GRA),
        .cpu_wr_lo(hit && wr_lo && CPU_REQ.idx == IDX_GRA),
        .cpu_wdata(wdata16),
        .hw_ld(CAP_A[g]),
        .hw_data(timer_count[g]),
        .q(general_reg_a[g])
      );
      mct_reg16 u_grb (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .cpu_wr_hi(hit && wr_hi && CPU_REQ.idx == IDX_GRB),
        .cpu_wr_lo(hit && wr_lo && CPU_REQ.idx == IDX_GRB),
        .cpu_wdata(wdata16),
        .hw_ld(CAP_B[g]),
        .hw_data(timer_count[g]),
        .q(general_reg_b[g])
      );
      // buffer keeps the prior general value on capture
      mct_reg16 u_bra (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .cpu_wr_hi(hit && wr_hi && CPU_REQ.idx == IDX_BRA),
        .cpu_wr_lo(hit && wr_lo && CPU_REQ.idx == IDX_BRA),
        .cpu_wdata(wdata16),
        .hw_ld(CAP_A[g]),
        .hw_data(general_reg_a[g]),
        .q(buffer_reg_a[g])
      );
      mct_reg16 u_brb (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .cpu_wr_hi(hit && wr_hi && CPU_REQ.idx == IDX_BRB),
        .cpu_wr_lo(hit && wr_lo && CPU_REQ.idx == IDX_BRB),
        .cpu_wdata(wdata16),
        .hw_ld(CAP_B[g]),
        .hw_data(general_reg_b[g]),
        .q(buffer_reg_b[g])
      );

      // requests registered; they follow flag and enable one edge late
      always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          WRAP_IRQ[g] <= 1'b0;
          MATCH_B_IRQ[g] <= 1'b0;
          MATCH_A_IRQ[g] <= 1'b0;
        end else begin
          WRAP_IRQ[g] <= timer_flag_reg[g][EN_WRAP_BIT] && timer_irq_enable_r[g][EN_WRAP_BIT]; // [R4] [R15]
          MATCH_B_IRQ[g] <= timer_flag_reg[g][EN_B_BIT] && timer_irq_enable_r[g][EN_B_BIT]; // [R5] [R15]
          MATCH_A_IRQ[g] <= timer_flag_reg[g][EN_A_BIT] && timer_irq_enable_r[g][EN_A_BIT]; // [R6] [R15]
        end
      end
    end
  endgenerate

  // read mux; 8-bit registers answer in the low byte
  function automatic logic [15:0] pick16(input logic [15:0] v);
    if (CPU_REQ.word) pick16 = v;
    else if (CPU_BYTE_ODD) pick16 = {RD_NONE, v[7:0]}; // [R16]
    else pick16 = {RD_NONE, v[15:8]};
  endfunction

  always_comb begin
    rdata_nxt = {RD_NONE, RD_NONE};
    for (int i = 0; i < NUM_CH; i++) begin
      if (CPU_REQ.sel && !CPU_REQ.wr && CPU_REQ.ch == 3'(i)) begin
        unique case (CPU_REQ.idx)
          IDX_FLAG: rdata_nxt = {RD_NONE, FLAG_RESET[7:FIX_LSB], timer_flag_reg[i]};
          IDX_IRQ_EN: rdata_nxt = {RD_NONE, IRQ_EN_FIXED, timer_irq_enable_r[i]}; // [R3]
          IDX_CTRL: rdata_nxt = {RD_NONE, timer_control_reg_r[i]}; // [R10]
          IDX_CNT: rdata_nxt = pick16(timer_count[i]); // [R9]
          IDX_GRA: rdata_nxt = pick16(general_reg_a[i]);
          IDX_GRB: rdata_nxt = pick16(general_reg_b[i]);
          IDX_BRA: rdata_nxt = pick16(buffer_reg_a[i]);
          IDX_BRB: rdata_nxt = pick16(buffer_reg_b[i]);
          default: rdata_nxt = {RD_NONE, RD_NONE};
        endcase
      end
    end
  end

  // word access to an 8-bit register is the processor's job to split
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) CPU_RDATA <= {RD_NONE, RD_NONE};
    else CPU_RDATA <= rdata_nxt; // [R11]
  end
endmodule // mct_irq_port

// >>> mct_pkg.sv
// package for the five-channel timer enable and processor port block
// assumes one system clock and an asynchronous active-low reset
package mct_pkg;
  localparam int NUM_CH = 5;
  localparam logic [7:0] IRQ_EN_RESET = 8'hF8;
  localparam logic [4:0] IRQ_EN_FIXED = 5'h1F;
  localparam int EN_A_BIT = 0;
  localparam int EN_B_BIT = 1;
  localparam int EN_WRAP_BIT = 2;
  localparam int FIX_LSB = 3;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] FLAG_RESET = 8'hF8;
  // register index inside a channel window
  localparam logic [3:0] IDX_FLAG = 4'h0;
  localparam logic [3:0] IDX_IRQ_EN = 4'h1;
  localparam logic [3:0] IDX_CTRL = 4'h2;
  localparam logic [3:0] IDX_CNT = 4'h4;
  localparam logic [3:0] IDX_GRA = 4'h6;
  localparam logic [3:0] IDX_GRB = 4'h8;
  localparam logic [3:0] IDX_BRA = 4'hA;
  localparam logic [3:0] IDX_BRB = 4'hC;
  localparam logic [7:0] RD_NONE = 8'h00;

  typedef struct packed {
    logic sel;
    logic wr;
    logic word;
    logic [2:0] ch;
    logic [3:0] idx;
    logic [15:0] wdata;
  } mct_req_t;

  typedef struct packed {
    logic wrap;
    logic match_b;
    logic match_a;
  } mct_evt_t;
endpackage

// >>> mct_reg16.sv
// one 16-bit timer register with word and byte processor access
// assumes writes from the counter side arrive as a full load strobe
module mct_reg16 (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // processor side
  input wire logic cpu_wr_hi,
  input wire logic cpu_wr_lo,
  input wire logic [15:0] cpu_wdata,
  // hardware side
  input wire logic hw_ld,
  input wire logic [15:0] hw_data,
  // stored value
  output logic [15:0] q
);
  import mct_pkg::*;
  // upper half lives at the even byte address, lower at odd
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= CNT_MIN;
    end else if (cpu_wr_hi || cpu_wr_lo) begin // [R9] [R16]
      if (cpu_wr_hi) q[15:8] <= cpu_wdata[15:8];
      if (cpu_wr_lo) q[7:0] <= cpu_wdata[7:0];
    end else if (hw_ld) begin
      q <= hw_data;
    end
  end
endmodule // mct_reg16

// >>> mct_chan_flags.sv
// per-channel status flags with read-then-write-zero clearing
// assumes the event inputs are single-cycle pulses on the system clock
module mct_chan_flags (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic standby,
  // events and processor access
  input mct_pkg::mct_evt_t evt,
  input wire logic flag_rd,
  input wire logic flag_wr,
  input wire logic [2:0] flag_wdata,
  // flags
  output logic [2:0] flags
);
  import mct_pkg::*;
  logic [2:0] armed_r;
  logic [2:0] set_v;
  assign set_v = {evt.wrap, evt.match_b, evt.match_a};
  // a bit is armed once read as one; only then may a zero clear it
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      flags <= 3'h0;
      armed_r <= 3'h0;
    end else if (standby) begin
      flags <= 3'h0;
      armed_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // set wins over a clear in the same cycle
        if (set_v[i]) flags[i] <= 1'b1; // [R12] [R14]
        else if (flag_wr && !flag_wdata[i] && armed_r[i]) flags[i] <= 1'b0; // [R13]
        if (flag_wr) armed_r[i] <= 1'b0;
        else if (flag_rd && flags[i]) armed_r[i] <= 1'b1;
      end
    end
  end
endmodule // mct_chan_flags

// >>> mct_irq_port_asserts.sv
// checker for the enable logic and processor port
// assumes binding onto the top module ports
module mct_irq_port_asserts import mct_pkg::*; (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic STANDBY,
  // processor access
  input mct_req_t CPU_REQ,
  input wire logic [15:0] CPU_RDATA,
  // requests
  input wire logic [4:0] WRAP_IRQ,
  input wire logic [4:0] MATCH_B_IRQ,
  input wire logic [4:0] MATCH_A_IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  logic rd;
  logic en_wr;
  logic flag_en_wr;
  // a flag or enable write, or standby, two edges back is the only legal cause of a drop
  assign flag_en_wr = CPU_REQ.sel && CPU_REQ.wr && CPU_REQ.idx <= IDX_IRQ_EN;
  assign rd = CPU_REQ.sel && !CPU_REQ.wr;
  assign en_wr = CPU_REQ.sel && CPU_REQ.wr && CPU_REQ.idx == IDX_IRQ_EN && CPU_REQ.ch < 3'h5;
  sequence sb_idle;
    STANDBY && !CPU_REQ.sel;
  endsequence
  sequence en_read;
    rd && CPU_REQ.idx == IDX_IRQ_EN && CPU_REQ.ch < 3'h5;
  endsequence
  rdata_idle_a: assert property (!rd |=> CPU_RDATA == 16'h0000) else $error("data without read");
  en_fixed_a: assert property (en_read |=> CPU_RDATA[15:3] == 13'h001F) else $error("fixed bits");
  wrap_gate_a: assert property (en_wr && !CPU_REQ.wdata[EN_WRAP_BIT] |=> ##1
    !WRAP_IRQ[$past(CPU_REQ.ch, 2)]) else $error("wrap not gated");
  mb_gate_a: assert property (en_wr && !CPU_REQ.wdata[EN_B_BIT] |=> ##1
    !MATCH_B_IRQ[$past(CPU_REQ.ch, 2)]) else $error("match b not gated");
  ma_gate_a: assert property (en_wr && !CPU_REQ.wdata[EN_A_BIT] |=> ##1
    !MATCH_A_IRQ[$past(CPU_REQ.ch, 2)]) else $error("match a not gated");
  sb_irq_a: assert property (STANDBY |=> ##1
    (WRAP_IRQ | MATCH_B_IRQ | MATCH_A_IRQ) == 5'h00) else $error("request after standby");
  sb_read_a: assert property (sb_idle ##1 en_read |=> CPU_RDATA == 16'h00F8)
    else $error("enable not reset by standby");
  // requests are registered, so a drop shows two edges after its cause
  irq_hold_a: assert property (|(($past(WRAP_IRQ) & ~WRAP_IRQ)
    | ($past(MATCH_B_IRQ) & ~MATCH_B_IRQ) | ($past(MATCH_A_IRQ) & ~MATCH_A_IRQ))
    |-> $past(STANDBY, 2) || $past(flag_en_wr, 2))
    else $error("request dropped without cause");
  chan_range_a: assert property (rd && CPU_REQ.ch > 3'h4 |=> CPU_RDATA == 16'h0000)
    else $error("sixth channel answered");
endmodule // mct_irq_port_asserts
bind mct_irq_port mct_irq_port_asserts chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .STANDBY(STANDBY),
  .CPU_REQ(CPU_REQ), .CPU_RDATA(CPU_RDATA), .WRAP_IRQ(WRAP_IRQ), .MATCH_B_IRQ(MATCH_B_IRQ),
  .MATCH_A_IRQ(MATCH_A_IRQ));

// >>> mct_cpu_model.sv
// processor model issuing single-cycle register accesses
// assumes requests are taken at the rising edge after the falling-edge drive
module mct_cpu_model import mct_pkg::*; (
  input wire logic SYS_CLK,
  output mct_req_t CPU_REQ,
  output logic CPU_BYTE_ODD
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    CPU_REQ = '0;
    CPU_BYTE_ODD = 1'b0;
  end
  task automatic cyc(input logic w, word, input logic [2:0] ch, input logic [3:0] idx,
      input logic [15:0] wd, input logic odd);
    @(negedge SYS_CLK);
    CPU_REQ <= '{1'b1, w, word, ch, idx, wd};
    CPU_BYTE_ODD <= odd;
    @(posedge SYS_CLK);
  endtask
  task automatic idle;
    @(negedge SYS_CLK);
    CPU_REQ <= '0;
  endtask
  task automatic access(input logic w, word, input logic [2:0] ch, input logic [3:0] idx,
      input logic [15:0] wd, input logic odd);
    // byte registers only see bytes, upper byte goes to the even one
    if (word && idx < IDX_CNT) begin
      cyc(w, 1'b0, ch, idx, {8'h00, wd[15:8]}, 1'b0);
      cyc(w, 1'b0, ch, idx + 4'h1, {8'h00, wd[7:0]}, 1'b0);
    end else begin
      cyc(w, word, ch, idx, wd, odd);
    end
  endtask
endmodule // mct_cpu_model

// >>> timer_irq_enable_cpu_port_bench.sv
// self-checking bench for the enable logic and processor port
// assumes the processor model drives all requests
module timer_irq_enable_cpu_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mct_pkg::*;
  logic SYS_CLK, RSTN, STANDBY, CPU_BYTE_ODD;
  mct_req_t CPU_REQ;
  logic [15:0] CPU_RDATA;
  logic [4:0] CNT_TICK, CNT_DOWN, CAP_A, CAP_B, WRAP_IRQ, MATCH_B_IRQ, MATCH_A_IRQ;
  logic [4:0] CMP_MODE_A, CMP_MODE_B;
  int failures = 0;
  int checks = 0;
  logic [31:0] seed = 32'd38;
  logic [31:0] r;
  logic [2:0] v [5];
  logic [15:0] expq [$];
  mct_irq_port uut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .STANDBY(STANDBY), .CPU_REQ(CPU_REQ),
    .CPU_BYTE_ODD(CPU_BYTE_ODD), .CPU_RDATA(CPU_RDATA), .CNT_TICK(CNT_TICK), .CNT_DOWN(CNT_DOWN),
    .CAP_A(CAP_A), .CAP_B(CAP_B), .CMP_MODE_A(CMP_MODE_A), .CMP_MODE_B(CMP_MODE_B),
    .WRAP_IRQ(WRAP_IRQ), .MATCH_B_IRQ(MATCH_B_IRQ), .MATCH_A_IRQ(MATCH_A_IRQ));
  mct_cpu_model cpu (.SYS_CLK(SYS_CLK), .CPU_REQ(CPU_REQ), .CPU_BYTE_ODD(CPU_BYTE_ODD));
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [2:0] ch, input logic [3:0] idx, input logic word,
      input logic [15:0] wd, input logic odd);
    cpu.access(1'b1, word, ch, idx, wd, odd);
    cpu.idle();
  endtask
  task automatic rd(input logic [2:0] ch, input logic [3:0] idx, input logic word,
      input logic [15:0] e, input logic odd = 1'b0);
    expq.push_back(e);
    cpu.access(1'b0, word, ch, idx, 16'h0000, odd);
    cpu.idle();
  endtask
  task automatic irq_is(input int k, input logic [2:0] e);
    repeat (3) @(negedge SYS_CLK);
    check({13'h0000, WRAP_IRQ[k], MATCH_B_IRQ[k], MATCH_A_IRQ[k]}, {13'h0000, e});
  endtask
  // read data stands one time unit after the edge that took the read
  always @(posedge SYS_CLK) begin
    if (RSTN && CPU_REQ.sel && !CPU_REQ.wr) begin
      #1;
      check(CPU_RDATA, expq.pop_front());
    end
  end
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    {RSTN, STANDBY, CNT_TICK, CNT_DOWN, CAP_A, CAP_B, CMP_MODE_A, CMP_MODE_B} = '0;
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK) RSTN <= 1'b1;
    for (int c = 0; c < 6; c++) rd(c, IDX_IRQ_EN, 1'b0, c < 5 ? 16'h00F8 : 16'h0000);
    $display("reset values done");
    for (int c = 0; c < 5; c++) begin
      r = xs();
      v[c] = r[2:0];
      wr(c, IDX_IRQ_EN, 1'b0, r[15:0], 1'b0);
    end
    for (int c = 0; c < 5; c++) rd(c, IDX_IRQ_EN, 1'b0, {8'h00, 5'h1F, v[c]});
    $display("enable access done");
    for (int d = 0; d < 2; d++) begin
      automatic int k = d ? 2 : 4;
      wr(k, IDX_IRQ_EN, 1'b0, 16'h0000, 1'b0);
      CNT_DOWN[k] <= d[0];
      wr(k, IDX_CNT, 1'b1, d ? CNT_MIN : CNT_MAX, 1'b0);
      CNT_TICK[k] <= 1'b1;
      CAP_A[k] <= 1'b1;
      CAP_B[k] <= 1'b1;
      @(negedge SYS_CLK) {CNT_TICK, CAP_A, CAP_B} <= '0;
      irq_is(k, 3'b000);
      wr(k, IDX_FLAG, 1'b1, d ? 16'hFF02 : 16'hFF05, 1'b0);
      irq_is(k, d ? 3'b010 : 3'b101);
      // a zero written before any read must leave the flags alone
      wr(k, IDX_FLAG, 1'b0, 16'h0000, 1'b0);
      irq_is(k, d ? 3'b010 : 3'b101);
      rd(k, IDX_FLAG, 1'b0, 16'h00FF);
      wr(k, IDX_FLAG, 1'b0, 16'h00F8, 1'b0);
      irq_is(k, 3'b000);
    end
    $display("request gating done");
    r = xs();
    wr(1, IDX_GRA, 1'b1, r[15:0], 1'b0);
    rd(1, IDX_GRA, 1'b1, r[15:0]);
    wr(1, IDX_GRB, 1'b0, {8'h00, r[23:16]}, 1'b0);
    wr(1, IDX_GRB, 1'b0, {8'h00, r[31:24]}, 1'b1);
    rd(1, IDX_GRB, 1'b1, {r[23:16], r[31:24]});
    rd(1, IDX_GRB, 1'b0, {8'h00, r[23:16]});
    rd(1, IDX_GRB, 1'b0, {8'h00, r[31:24]}, 1'b1);
    wr(3, IDX_CTRL, 1'b0, r[31:16], 1'b0);
    rd(3, IDX_CTRL, 1'b0, {8'h00, r[23:16]});
    $display("wide registers done");
    // compare match on A only; B is one off so it must not match
    wr(0, IDX_IRQ_EN, 1'b0, 16'h0003, 1'b0);
    wr(0, IDX_GRA, 1'b1, r[15:0], 1'b0);
    wr(0, IDX_GRB, 1'b1, r[15:0] + 16'h0001, 1'b0);
    wr(0, IDX_CNT, 1'b1, r[15:0], 1'b0);
    {CMP_MODE_A[0], CMP_MODE_B[0], CNT_TICK[0]} <= 3'h7;
    @(negedge SYS_CLK) {CNT_TICK, CMP_MODE_A, CMP_MODE_B} <= '0;
    irq_is(0, 3'b001);
    $display("compare done");
    CAP_B[2] <= 1'b1;
    @(negedge SYS_CLK) CAP_B <= '0;
    irq_is(2, 3'b010);
    @(negedge SYS_CLK) STANDBY <= 1'b1;
    rd(4, IDX_IRQ_EN, 1'b0, 16'h00F8);
    STANDBY <= 1'b0;
    irq_is(2, 3'b000);
    $display("standby done");
    wr(4, IDX_IRQ_EN, 1'b0, 16'h0007, 1'b0);
    RSTN <= 1'b0;
    repeat (2) @(negedge SYS_CLK);
    RSTN <= 1'b1;
    rd(4, IDX_IRQ_EN, 1'b0, 16'h00F8);
    rd(1, IDX_GRA, 1'b1, 16'h0000);
    $display("second reset done");
    close_out();
  end
endmodule // timer_irq_enable_cpu_port_bench
